// [core/dvt_buf2.sv]
/*
  Two-entry valid/ready buffer carrying serial words to the user.
  Assumes the writer only pushes while in_ready is high; outputs are flops.
*/
`timescale 1ns/1ns
module dvt_buf2 (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [dvt_pkg::LANES-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [dvt_pkg::LANES-1:0] out_data
);
  logic [dvt_pkg::LANES-1:0] tail;
  logic tail_v;
  logic [dvt_pkg::LANES-1:0] next_head, next_tail;
  logic next_head_v, next_tail_v;

  always_comb begin
    next_head = out_data;
    next_head_v = out_valid;
    next_tail = tail;
    next_tail_v = tail_v;
    if (out_valid && out_ready) begin
      next_head = tail;
      next_head_v = tail_v;
      next_tail_v = 1'b0;
    end
    if (in_valid && in_ready) begin
      if (!next_head_v) begin
        next_head = in_data;
        next_head_v = 1'b1;
      end else begin
        next_tail = in_data;
        next_tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_data <= 4'h0;
      out_valid <= 1'b0;
      tail <= 4'h0;
      tail_v <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      out_data <= next_head;
      out_valid <= next_head_v;
      tail <= next_tail;
      tail_v <= next_tail_v;
      in_ready <= !next_tail_v;
    end
  end

  no_overflow_a: assert property (@(posedge core_clk) disable iff (rst)
    in_valid |-> in_ready) else $error("serial word pushed into a full buffer");
endmodule

// [core/dvt_host.sv]
/*
  Host sequencer for a 65,536 x 4 dual-port video memory module: random
  read/write, transfers between array and serial registers, serial fill and
  stream, row refresh and serial register keep-alive while streaming.
  Assumes core_clk at 25 MHz and pins wired straight to the module.
*/
`timescale 1ns/1ns
module dvt_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [dvt_pkg::AW-1:0] cmd_row,
  input wire logic [dvt_pkg::AW-1:0] cmd_col,
  input wire logic [dvt_pkg::LANES-1:0] cmd_wdata,
  input wire logic [dvt_pkg::LANES-1:0] cmd_lane,
  output logic rd_valid,
  output logic [dvt_pkg::LANES-1:0] rd_data,
  output logic sout_valid,
  input wire logic sout_ready,
  output logic [dvt_pkg::LANES-1:0] sout_data,
  input wire logic sin_valid,
  output logic sin_ready,
  input wire logic [dvt_pkg::LANES-1:0] sin_data,
  output logic sr_expired,
  output logic ras_n,
  output logic [dvt_pkg::LANES-1:0] column_strobe_n,
  output logic write_n,
  output logic transfer_or_output_enable,
  output logic sclk,
  output logic serial_out_enable_n,
  output logic [dvt_pkg::AW-1:0] mux_address,
  output logic [dvt_pkg::LANES-1:0] random_data_io_drive,
  output logic random_data_io_oe,
  input wire logic [dvt_pkg::LANES-1:0] random_data_io_sense,
  output logic [dvt_pkg::LANES-1:0] serial_data_io_drive,
  output logic serial_data_io_oe,
  input wire logic [dvt_pkg::LANES-1:0] serial_data_io_sense
);
  dvt_pkg::dvt_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [2:0] kind, next_kind;
  logic [1:0] smode, next_smode;
  logic [dvt_pkg::AW-1:0] col, next_col, sr_row, next_sr_row, next_addr;
  logic [dvt_pkg::LANES-1:0] wdata, next_wdata, lane, next_lane;
  logic [8:0] pos, next_pos, skip, next_skip;
  logic pending, next_pending, push, next_push, sr_live, next_sr_live;
  logic [10:0] sr_age, next_sr_age;
  logic [dvt_pkg::LANES-1:0] push_data, next_push_data, next_cas_n, next_rd_data, next_dq, next_sio;
  logic next_ras_n, next_write_n, next_tr, next_sclk, next_soe_n, next_dq_oe, next_sio_oe;
  logic next_cmd_ready, next_rd_valid, next_sin_ready, next_sr_expired;
  logic buf_in_ready, ref_take, ref_due, next_ref_due;
  logic [8:0] ref_timer, next_ref_timer;
  logic [dvt_pkg::AW-1:0] ref_row, next_ref_row;
  logic [dvt_pkg::LANES-1:0] dq_s1, dq_s2, dq_s3, dq_f, sio_s1, sio_s2, sio_s3, sio_f;

  // pin inputs: three flops, value taken once the last two agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_s1 <= 4'h0; dq_s2 <= 4'h0; dq_s3 <= 4'h0; dq_f <= 4'h0;
      sio_s1 <= 4'h0; sio_s2 <= 4'h0; sio_s3 <= 4'h0; sio_f <= 4'h0;
    end else begin
      dq_s1 <= random_data_io_sense; dq_s2 <= dq_s1; dq_s3 <= dq_s2;
      sio_s1 <= serial_data_io_sense; sio_s2 <= sio_s1; sio_s3 <= sio_s2;
      if (dq_s2 == dq_s3) dq_f <= dq_s3;
      if (sio_s2 == sio_s3) sio_f <= sio_s3;
    end
  end

  // one row per interval keeps all rows inside the refresh period
  always_comb begin
    next_ref_timer = (ref_timer == 9'(dvt_pkg::REFI_CYC - 1)) ? 9'h000 : ref_timer + 9'h001;
    next_ref_due = (ref_timer == 9'(dvt_pkg::REFI_CYC - 1)) || (ref_due && !ref_take);
    next_ref_row = ref_take ? ref_row + 8'h01 : ref_row;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_timer <= 9'h000;
      ref_due <= 1'b0;
      ref_row <= 8'h00;
    end else begin
      ref_timer <= next_ref_timer;
      ref_due <= next_ref_due;
      ref_row <= next_ref_row;
    end
  end

  always_comb begin
    next_state = state; next_cnt = cnt; next_kind = kind; next_smode = smode;
    next_col = col; next_sr_row = sr_row; next_addr = mux_address;
    next_wdata = wdata; next_lane = lane; next_pos = pos; next_skip = skip;
    next_pending = pending; next_push = 1'b0; next_push_data = push_data;
    next_sr_live = sr_live; next_cas_n = column_strobe_n; next_rd_data = rd_data;
    next_dq = random_data_io_drive; next_sio = serial_data_io_drive;
    next_ras_n = ras_n; next_write_n = write_n; next_tr = transfer_or_output_enable;
    next_sclk = sclk; next_soe_n = serial_out_enable_n;
    next_dq_oe = random_data_io_oe; next_sio_oe = serial_data_io_oe;
    next_cmd_ready = 1'b0; next_rd_valid = 1'b0; next_sin_ready = sin_ready;
    next_sr_expired = 1'b0; ref_take = 1'b0;
    next_sr_age = !sr_live ? 11'h000 : (sr_age == 11'h7FF ? sr_age : sr_age + 11'h001);
    case (state)
      dvt_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_kind = cmd_op; next_col = cmd_col; next_wdata = cmd_wdata; next_lane = cmd_lane;
          next_pos = 9'h000; next_skip = 9'h000; next_pending = 1'b0; next_cnt = 4'h0;
          if (cmd_op == dvt_pkg::OP_FILL) begin
            next_smode = dvt_pkg::SM_IN; next_soe_n = 1'b1; next_sio_oe = 1'b1;
            next_sr_live = 1'b1; next_sr_age = 11'h000; next_state = dvt_pkg::ST_SLOW;
          end else if (cmd_op == dvt_pkg::OP_STREAM) begin
            next_smode = dvt_pkg::SM_OUT; next_soe_n = 1'b0; next_sio_oe = 1'b0;
            next_cnt = 4'(dvt_pkg::RHSC_CYC - 1); next_state = dvt_pkg::ST_SLOW;
          end else begin
            next_addr = cmd_row;
            next_tr = !(cmd_op == dvt_pkg::OP_LOAD || cmd_op == dvt_pkg::OP_STORE);
            next_write_n = (cmd_op != dvt_pkg::OP_STORE);
            next_state = dvt_pkg::ST_SETUP;
          end
        end else if (ref_due) begin
          ref_take = 1'b1; next_kind = dvt_pkg::OP_REFRESH; next_addr = ref_row;
          next_tr = 1'b1; next_write_n = 1'b1; next_state = dvt_pkg::ST_SETUP;
        end else begin
          next_cmd_ready = 1'b1;
          // stored-up serial data cannot survive an idle gap this long
          if (sr_live && sr_age >= 11'(dvt_pkg::SR_AGE_LIM)) begin
            next_sr_live = 1'b0; next_sr_expired = 1'b1;
          end
        end
      end
      dvt_pkg::ST_SETUP: begin
        // sclk has been low at least one cycle here, well over 10 ns
        next_ras_n = 1'b0;
        next_state = dvt_pkg::ST_RAS;
        if (kind == dvt_pkg::OP_READ || kind == dvt_pkg::OP_WRITE) begin
          next_cnt = 4'(dvt_pkg::RCD_CYC - 1);
        end else begin
          next_cnt = 4'(dvt_pkg::RAS_CYC - 1);
        end
        if (kind == dvt_pkg::OP_LOAD) begin
          next_sr_live = 1'b1; next_sr_row = mux_address; next_sr_age = 11'h000;
        end
        if (kind == dvt_pkg::OP_STORE) next_sr_live = 1'b0;
      end
      dvt_pkg::ST_RAS: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (kind == dvt_pkg::OP_READ || kind == dvt_pkg::OP_WRITE) begin
          next_addr = col;
          next_cas_n = (kind == dvt_pkg::OP_READ) ? 4'h0 : ~lane;
          next_write_n = (kind != dvt_pkg::OP_WRITE);
          next_tr = (kind != dvt_pkg::OP_READ);
          next_dq_oe = (kind == dvt_pkg::OP_WRITE); next_dq = wdata;
          next_cnt = (kind == dvt_pkg::OP_READ) ? 4'(dvt_pkg::CAS_CYC + dvt_pkg::SYNC_CYC - 1)
                                                : 4'(dvt_pkg::CAS_CYC - 1);
          next_state = dvt_pkg::ST_CAS;
        end else begin
          next_ras_n = 1'b1; next_tr = 1'b1; next_write_n = 1'b1;
          next_cnt = (kind == dvt_pkg::OP_STORE) ? 4'(dvt_pkg::XW_CYC - 1) : 4'(dvt_pkg::RP_CYC - 1);
          next_state = dvt_pkg::ST_PRE;
        end
      end
      dvt_pkg::ST_CAS: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          if (kind == dvt_pkg::OP_READ) begin
            next_rd_data = dq_f; next_rd_valid = 1'b1;
          end
          next_cas_n = 4'hF; next_ras_n = 1'b1; next_tr = 1'b1; next_write_n = 1'b1;
          next_dq_oe = 1'b0; next_cnt = 4'(dvt_pkg::RP_CYC - 1); next_state = dvt_pkg::ST_PRE;
        end
      end
      dvt_pkg::ST_PRE: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (smode != dvt_pkg::SM_NONE) begin
          next_state = dvt_pkg::ST_SLOW; // precharge already covers ras-high to sclk
        end else begin
          next_state = dvt_pkg::ST_IDLE;
        end
      end
      dvt_pkg::ST_SLOW: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (pending && smode == dvt_pkg::SM_OUT) begin
          next_pending = 1'b0;
          if (skip != 9'h000) begin
            next_skip = skip - 9'h001;
          end else begin
            next_push = 1'b1; next_push_data = sio_f;
          end
        end else if (pending) begin
          next_pending = 1'b0; next_sclk = 1'b1; next_sr_age = 11'h000;
          next_state = dvt_pkg::ST_SHIGH;
        end else if (pos == 9'(dvt_pkg::SR_LEN)) begin
          // fill ends only after 256 clocks, an even count
          next_sr_live = (smode == dvt_pkg::SM_IN);
          next_smode = dvt_pkg::SM_NONE; next_soe_n = 1'b1; next_sio_oe = 1'b0;
          next_state = dvt_pkg::ST_IDLE;
        end else if (ref_due) begin
          ref_take = 1'b1; next_kind = dvt_pkg::OP_REFRESH; next_addr = ref_row;
          next_tr = 1'b1; next_write_n = 1'b1; next_state = dvt_pkg::ST_SETUP;
        end else if (smode == dvt_pkg::SM_OUT && sr_age >= 11'(dvt_pkg::SR_AGE_LIM)) begin
          // stalled reader: reload the row and skip words already delivered
          next_kind = dvt_pkg::OP_LOAD; next_addr = sr_row; next_tr = 1'b0;
          // a second reload before any new word must still skip what went out earlier
          next_write_n = 1'b1; next_skip = pos + skip; next_pos = 9'h000; next_state = dvt_pkg::ST_SETUP;
        end else if (smode == dvt_pkg::SM_OUT) begin
          if (buf_in_ready && !push) begin
            next_sclk = 1'b1; next_pos = pos + 9'h001; next_pending = 1'b1;
            next_sr_age = 11'h000; next_state = dvt_pkg::ST_SHIGH;
          end
        end else begin
          next_sin_ready = 1'b1; next_state = dvt_pkg::ST_SINW;
        end
      end
      dvt_pkg::ST_SHIGH: begin
        next_sclk = 1'b0;
        next_cnt = (smode == dvt_pkg::SM_OUT) ? 4'(dvt_pkg::SO_WAIT_CYC - 1) : 4'h0;
        next_state = dvt_pkg::ST_SLOW;
      end
      dvt_pkg::ST_SINW: begin
        if (sin_valid && sin_ready) begin
          // data leads the clock edge by a full cycle for setup
          next_sio = sin_data; next_sin_ready = 1'b0; next_pos = pos + 9'h001;
          next_pending = 1'b1; next_cnt = 4'h0; next_state = dvt_pkg::ST_SLOW;
        end else if (ref_due) begin
          next_sin_ready = 1'b0; next_state = dvt_pkg::ST_SLOW;
        end else if (sr_live && sr_age >= 11'(dvt_pkg::SR_AGE_LIM)) begin
          next_sr_live = 1'b0; next_sr_expired = 1'b1;
        end
      end
      default: next_state = dvt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= dvt_pkg::ST_IDLE; cnt <= 4'h0; kind <= 3'h0; smode <= 2'h0;
      col <= 8'h00; sr_row <= 8'h00; wdata <= 4'h0; lane <= 4'h0;
      pos <= 9'h000; skip <= 9'h000; pending <= 1'b0; push <= 1'b0; push_data <= 4'h0;
      sr_live <= 1'b0; sr_age <= 11'h000; mux_address <= 8'h00; column_strobe_n <= 4'hF;
      ras_n <= 1'b1; write_n <= 1'b1; transfer_or_output_enable <= 1'b1; sclk <= 1'b0;
      serial_out_enable_n <= 1'b1; random_data_io_drive <= 4'h0; random_data_io_oe <= 1'b0;
      serial_data_io_drive <= 4'h0; serial_data_io_oe <= 1'b0; cmd_ready <= 1'b0;
      rd_valid <= 1'b0; rd_data <= 4'h0; sin_ready <= 1'b0; sr_expired <= 1'b0;
    end else begin
      state <= next_state; cnt <= next_cnt; kind <= next_kind; smode <= next_smode;
      col <= next_col; sr_row <= next_sr_row; wdata <= next_wdata; lane <= next_lane;
      pos <= next_pos; skip <= next_skip; pending <= next_pending; push <= next_push;
      push_data <= next_push_data; sr_live <= next_sr_live; sr_age <= next_sr_age;
      mux_address <= next_addr; column_strobe_n <= next_cas_n; ras_n <= next_ras_n;
      write_n <= next_write_n; transfer_or_output_enable <= next_tr; sclk <= next_sclk;
      serial_out_enable_n <= next_soe_n; random_data_io_drive <= next_dq;
      random_data_io_oe <= next_dq_oe; serial_data_io_drive <= next_sio;
      serial_data_io_oe <= next_sio_oe; cmd_ready <= next_cmd_ready; rd_valid <= next_rd_valid;
      rd_data <= next_rd_data; sin_ready <= next_sin_ready; sr_expired <= next_sr_expired;
    end
  end

  dvt_buf2 u_sbuf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(sout_valid),
    .out_ready(sout_ready),
    .out_data(sout_data)
  );

  // checks; helper counts ras-high cycles after a store transfer
  logic after_store;
  logic [4:0] gap;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      after_store <= 1'b0;
      gap <= 5'h00;
    end else begin
      if (!ras_n) after_store <= (kind == dvt_pkg::OP_STORE);
      gap <= !ras_n ? 5'h00 : (gap == 5'h1F ? gap : gap + 5'h01);
    end
  end

  default clocking dflt_cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence xfer_fall;
    $fell(ras_n) && !transfer_or_output_enable;
  endsequence
  sequence strobe_fall;
    $fell(ras_n);
  endsequence

  tr_high_shift_a: assert property (strobe_fall and (smode != dvt_pkg::SM_NONE && kind != dvt_pkg::OP_LOAD)
    |-> transfer_or_output_enable) else $error("transfer pin low at strobe fall while shifting");
  sclk_quiet_a: assert property (xfer_fall |-> !sclk && !$past(sclk))
    else $error("serial clock rose right before a transfer");
  store_gap_a: assert property (strobe_fall and after_store |-> $past(gap) >= 5'(dvt_pkg::XW_CYC))
    else $error("store transfers too close together");
  refresh_bound_a: assert property ($rose(ref_due) |-> ##[0:60] ref_take)
    else $error("refresh request not served in time");
  sr_age_a: assert property (sr_live |-> sr_age < 11'(dvt_pkg::SR_REF_CYC))
    else $error("serial register left unrefreshed too long");
  fill_even_a: assert property (state == dvt_pkg::ST_SLOW && smode == dvt_pkg::SM_IN
    && next_state == dvt_pkg::ST_IDLE |-> pos[0] == 1'b0 && pos == 9'(dvt_pkg::SR_LEN))
    else $error("fill ended on an odd clock count");
  dir_select_a: assert property (xfer_fall |-> write_n == (kind != dvt_pkg::OP_STORE))
    else $error("write enable gives wrong transfer direction");
  ras_width_a: assert property (strobe_fall |-> !ras_n [*4])
    else $error("row strobe low pulse too short");
  sclk_pulse_a: assert property ($rose(sclk) |=> !sclk ##1 !sclk)
    else $error("serial clock high or low phase too short");
endmodule

// [core/dvt_pkg.sv]
/*
  Constants, op codes and sequencer states for the host that drives a
  dual-port video memory module (random port plus 256-deep serial port).
  Assumes a single 25 MHz core clock; all pin timing is counted in its cycles.
*/
package dvt_pkg;
  localparam int CLK_MHZ = 25;
  localparam int LANES = 4;
  localparam int AW = 8;
  localparam int SR_LEN = 256;
  localparam int REF_ROWS = 256;
  // times as printed, cycle counts derived from them
  localparam int T_RAS_NS = 150;
  localparam int T_RP_NS = 80;
  localparam int T_CAS_NS = 100;
  localparam int T_RCD_NS = 25;
  localparam int T_XW_GAP_NS = 500;
  localparam int T_RHSC_NS = 80;
  localparam int T_SO_NS = 45;
  localparam int T_REF_MS = 4;
  localparam int T_SR_REF_NS = 50000;
  localparam int SYNC_CYC = 4;
  localparam int RAS_CYC = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int XW_CYC = (T_XW_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RHSC_CYC = (T_RHSC_NS * CLK_MHZ + 999) / 1000;
  localparam int SO_WAIT_CYC = (T_SO_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
  localparam int REFI_CYC = (T_REF_MS * 1000 * 1000 * CLK_MHZ / 1000) / REF_ROWS;
  localparam int SR_REF_CYC = T_SR_REF_NS * CLK_MHZ / 1000;
  localparam int SR_AGE_LIM = SR_REF_CYC / 2;
  // command codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_LOAD = 3'h2;
  localparam logic [2:0] OP_STORE = 3'h3;
  localparam logic [2:0] OP_FILL = 3'h4;
  localparam logic [2:0] OP_STREAM = 3'h5;
  localparam logic [2:0] OP_REFRESH = 3'h7;
  // serial activity
  localparam logic [1:0] SM_NONE = 2'h0;
  localparam logic [1:0] SM_OUT = 2'h1;
  localparam logic [1:0] SM_IN = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_RAS = 3'h2,
    ST_CAS = 3'h3,
    ST_PRE = 3'h4,
    ST_SLOW = 3'h5,
    ST_SHIGH = 3'h6,
    ST_SINW = 3'h7
  } dvt_state_e;
endpackage

// [tb/dvt_mem_model.sv]
/*
  Behavioural model of the 64K x 4 dual-port memory module on the host pins.
  Assumes the host pins as declared by dvt_host; counts timing slips in viol.
*/
`timescale 1ns/1ns
module dvt_mem_model (
  input wire logic ras_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic write_n,
  input wire logic transfer_or_output_enable,
  input wire logic sclk,
  input wire logic serial_out_enable_n,
  input wire logic [7:0] mux_address,
  input wire logic [3:0] random_data_io_drive,
  input wire logic random_data_io_oe,
  output logic [3:0] random_data_io_sense,
  input wire logic [3:0] serial_data_io_drive,
  input wire logic serial_data_io_oe,
  output logic [3:0] serial_data_io_sense,
  output int viol
);
  logic [3:0] mem [0:65535];
  logic [3:0] sr [0:255];
  logic [7:0] row = 0, col = 0, ptr = 0;
  logic [3:0] so_out = 0, dq_prev = 0, sd_prev = 0;
  logic other = 1;
  int fill_cnt = 0;
  realtime t_rise = -100, t_up = 0, last_ref [0:255];
  wire dq_en = !ras_n && column_strobe_n != 4'hF && write_n && !transfer_or_output_enable;
  initial viol = 0;
  initial foreach (last_ref[i]) last_ref[i] = 0;
  always @(negedge ras_n) begin
    row = mux_address;
    if ($realtime - last_ref[row] > 4.0e6) viol++;
    last_ref[row] = $realtime;
    if (transfer_or_output_enable === 1'b0) begin
      if ($realtime - t_rise < 10) viol++;
      ptr = 0;
      if (write_n === 1'b0) begin
        if (fill_cnt % 2 != 0) viol++;
        if (!other && $realtime - t_up < 500) viol++;
        for (int c = 0; c < 256; c++) mem[{row, 8'(c)}] = sr[c];
        other = 0;
      end else begin
        for (int c = 0; c < 256; c++) sr[c] = mem[{row, 8'(c)}];
        other = 1;
      end
      fill_cnt = 0;
    end else begin
      other = 1;
    end
  end
  always @(posedge ras_n) t_up = $realtime;
  // sampled 1 ns late so data and address launched on the same edge have landed
  always @(column_strobe_n) begin
    #1;
    if (!ras_n && column_strobe_n != 4'hF) begin
      col = mux_address;
      for (int i = 0; i < 4; i++)
        if (!write_n && !column_strobe_n[i]) mem[{row, col}][i] = random_data_io_sense[i];
    end
  end
  always @(posedge sclk) begin
    t_rise = $realtime;
    if (serial_data_io_oe) begin
      sr[ptr] = serial_data_io_sense;
      fill_cnt++;
    end
    so_out = sr[ptr];
    ptr++;
  end
  // released lines show the inverse of the last driven value
  assign random_data_io_sense = random_data_io_oe ? random_data_io_drive : dq_en ? mem[{row, col}] : ~dq_prev;
  assign serial_data_io_sense = serial_data_io_oe ? serial_data_io_drive : !serial_out_enable_n ? so_out : ~sd_prev;
  always @* if (random_data_io_oe) dq_prev = random_data_io_drive; else if (dq_en) dq_prev = mem[{row, col}];
  always @* if (serial_data_io_oe) sd_prev = serial_data_io_drive; else if (!serial_out_enable_n) sd_prev = so_out;
endmodule

// [tb/testbench.sv]
/*
  Self-checking bench for dvt_host against the memory module model.
  Assumes 25 MHz core_clk; inputs change on the falling edge.
*/
`timescale 1ns/1ns
module testbench;
  logic core_clk = 0, rst = 1, cmd_valid = 0, sout_ready = 0, sin_valid = 0;
  logic [2:0] cmd_op = 0;
  logic [7:0] cmd_row = 0, cmd_col = 0, mux_address;
  logic [3:0] cmd_wdata = 0, cmd_lane = 0, sin_data = 0, rd_data, sout_data, column_strobe_n;
  logic [3:0] random_data_io_drive, random_data_io_sense, serial_data_io_drive, serial_data_io_sense;
  logic cmd_ready, rd_valid, sout_valid, sin_ready, sr_expired, ras_n, write_n, transfer_or_output_enable;
  logic sclk, serial_out_enable_n, random_data_io_oe, serial_data_io_oe;
  int err_count = 0, n_tests = 0, viol, k, n;
  // op, row, col, wdata, lane mask, expected read
  localparam logic [30:0] ROWS [0:4] = '{{3'h1, 8'h01, 8'h02, 4'hF, 4'hF, 4'h0}, {3'h1, 8'h01, 8'h02, 4'h0, 4'h3, 4'h0},
    {3'h0, 8'h01, 8'h02, 4'h0, 4'h0, 4'hC}, {3'h1, 8'hFF, 8'hFF, 4'h5, 4'hF, 4'h0}, {3'h0, 8'hFF, 8'hFF, 4'h0, 4'h0, 4'h5}};
  always #20 core_clk = ~core_clk;
  dvt_host i_dut (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_row, .cmd_col, .cmd_wdata, .cmd_lane,
    .rd_valid, .rd_data, .sout_valid, .sout_ready, .sout_data, .sin_valid, .sin_ready, .sin_data, .sr_expired,
    .ras_n, .column_strobe_n, .write_n, .transfer_or_output_enable, .sclk, .serial_out_enable_n, .mux_address,
    .random_data_io_drive, .random_data_io_oe, .random_data_io_sense, .serial_data_io_drive, .serial_data_io_oe,
    .serial_data_io_sense);
  dvt_mem_model i_mem (.ras_n, .column_strobe_n, .write_n, .transfer_or_output_enable, .sclk, .serial_out_enable_n,
    .mux_address, .random_data_io_drive, .random_data_io_oe, .random_data_io_sense, .serial_data_io_drive,
    .serial_data_io_oe, .serial_data_io_sense, .viol);
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits at rising edges for a flag seen high before the edge's updates
  task automatic await(ref logic s);
    int w;
    w = 0;
    do begin
      @(posedge core_clk);
      w++;
    end while (s !== 1'b1 && w < 20000);
    if (w >= 20000) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic issue(input logic [2:0] op, input logic [7:0] r, input logic [7:0] c, input logic [3:0] d,
    input logic [3:0] m);
    @(negedge core_clk);
    {cmd_valid, cmd_op, cmd_row, cmd_col, cmd_wdata, cmd_lane} = {1'b1, op, r, c, d, m};
    await(cmd_ready);
    @(negedge core_clk);
    cmd_valid = 0;
  endtask
  task automatic read_chk(input logic [7:0] r, input logic [7:0] c, input logic [3:0] e);
    issue(dvt_pkg::OP_READ, r, c, 4'h0, 4'h0);
    await(rd_valid);
    check(rd_data, e);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    check({ras_n, write_n, transfer_or_output_enable, cmd_ready}, 4'hE);
    @(negedge core_clk);
    rst = 0;
    foreach (ROWS[i]) begin
      if (ROWS[i][30:28] == dvt_pkg::OP_READ) read_chk(ROWS[i][27:20], ROWS[i][19:12], ROWS[i][3:0]);
      else issue(ROWS[i][30:28], ROWS[i][27:20], ROWS[i][19:12], ROWS[i][11:8], ROWS[i][7:4]);
    end
    issue(dvt_pkg::OP_FILL, 8'h00, 8'h00, 4'h0, 4'h0);
    for (int i = 0; i < 256; i++) begin
      @(negedge core_clk);
      sin_valid = 1;
      sin_data = 4'(i) ^ 4'hA;
      await(sin_ready);
    end
    @(negedge core_clk);
    sin_valid = 0;
    issue(dvt_pkg::OP_STORE, 8'h05, 8'h00, 4'h0, 4'h0);
    read_chk(8'h05, 8'h03, 4'h9);
    issue(dvt_pkg::OP_LOAD, 8'h05, 8'h00, 4'h0, 4'h0);
    issue(dvt_pkg::OP_STREAM, 8'h05, 8'h00, 4'h0, 4'h0);
    // long stall makes the host reload the streamed row twice
    repeat (1400) @(negedge core_clk);
    check({3'h0, sout_valid}, 4'h1);
    k = 0;
    n = 0;
    // receiver stalls every other cycle while words stream out
    while (k < 256 && n < 20000) begin
      @(negedge core_clk);
      sout_ready = n[0];
      @(posedge core_clk);
      n++;
      if (sout_valid === 1'b1 && sout_ready) begin
        check(sout_data, 4'(k) ^ 4'hA);
        k++;
      end
    end
    check({3'h0, k == 256}, 4'h1);
    repeat (3) @(negedge core_clk);
    check({3'h0, sout_valid}, 4'h0);
    issue(dvt_pkg::OP_STORE, 8'h09, 8'h00, 4'h0, 4'h0);
    issue(dvt_pkg::OP_STORE, 8'h0A, 8'h00, 4'h0, 4'h0);
    read_chk(8'h09, 8'hC8, 4'h2);
    read_chk(8'h0A, 8'h01, 4'hB);
    // fill that stalls after two words must age out once
    issue(dvt_pkg::OP_FILL, 8'h00, 8'h00, 4'h0, 4'h0);
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk);
      sin_valid = 1;
      sin_data = 4'(i);
      await(sin_ready);
    end
    @(negedge core_clk);
    sin_valid = 0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sr_expired !== 1'b1 && n < 2000);
    check({3'h0, n >= dvt_pkg::SR_AGE_LIM + 3 && n <= dvt_pkg::SR_AGE_LIM + 40}, 4'h1);
    @(posedge core_clk);
    check({3'h0, sr_expired}, 4'h0);
    // mid-run reset ends the stuck fill; array contents must survive
    @(negedge core_clk);
    rst = 1;
    @(posedge core_clk);
    check({ras_n, transfer_or_output_enable, sin_ready, sclk}, 4'hC);
    @(negedge core_clk);
    rst = 0;
    read_chk(8'h0A, 8'h01, 4'hB);
    check(viol != 0 ? 4'hF : 4'h0, 4'h0);
    end_sim();
  end
endmodule
